// >>> tsr_slot_router.sv
// TDM serial output for two channels with per-channel slot routing
`timescale 1ns/1ps
// Behaviour
// - Channel 5 goes out in the slot its bits 7:4 name; reset 5.
// - Channel 5's bit 0 drives its slot at 1, floats it at 0 unless channel 6 drives it; reset 1.
// - Channel 6 goes out in the slot its bits 7:4 name unless channel 5 drives it; reset 6.
// - Channel 6's bit 0 drives its slot at 1, floats it at 0 unless channel 5 drives it; reset 1.
// - Bits 3:1 of both registers read zero; slot and drive are R/W.
module tsr_slot_router
  import tsr_pkg::*;
#(
  parameter int FIFO_DEPTH = TSR_FIFO_DEPTH
) (
  input wire logic clock,            // 200 MHz system clock
  input wire logic resetn,           // Async reset, active low
  input wire logic [7:0] reg_addr,   // Register address
  input wire logic [7:0] reg_wdata,  // Register write data
  input wire logic reg_wr,           // Write strobe, one cycle
  input wire logic reg_rd,           // Read strobe, one cycle
  input wire logic full_reset,       // Restore register defaults
  output logic [7:0] reg_rdata,      // Read data, registered
  output logic reg_rvalid,           // Read data valid, one cycle
  input wire logic sample_valid,     // New sample pair offered
  input tsr_sample_s sample_data,    // Channel 5 and 6 samples
  output logic sample_ready,         // FIFO has room
  input wire logic bclk,             // Bit clock, sampled
  input wire logic fsync,            // Frame clock, sampled
  output logic sdata_out,            // Serial data level
  output logic sdata_oe              // Serial data driven when high
);
  localparam int SW = $bits(tsr_sample_s);

  typedef struct packed {
    logic bclk_q;
    logic fsync_q;
    logic active;
    logic [TSR_CNT_W-1:0] cnt;
    tsr_sample_s cur;
    logic sdata;
    logic oe;
    logic [7:0] rdata;
    logic rvalid;
  } tsr_top_state_s;

  tsr_top_state_s st;
  tsr_top_state_s next_st;
  tsr_reg_req_s req;
  tsr_route_s route5;
  tsr_route_s route6;
  logic [7:0] rdata5;
  logic [7:0] rdata6;
  logic fifo_valid;
  tsr_sample_s fifo_data;
  logic [SW-1:0] fifo_raw;
  logic rise;
  logic fall;
  logic frame_start;
  logic [TSR_SLOT_IDX_W-1:0] cur_slot;
  logic [TSR_SLOT_LOG2-1:0] cur_bit;
  logic hit5;
  logic hit6;
  logic bit5;
  logic bit6;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Two identical routing registers, one per channel
  tsr_route_reg #(
    .ADDR(TSR_ROUTE5_ADDR),
    .RESET_VALUE(TSR_ROUTE5_RESET)
  ) u_route5 (
    .clock(clock),
    .resetn(resetn),
    .full_reset(full_reset),
    .req(req),
    .route(route5),
    .rdata(rdata5)
  );

  tsr_route_reg #(
    .ADDR(TSR_ROUTE6_ADDR),
    .RESET_VALUE(TSR_ROUTE6_RESET)
  ) u_route6 (
    .clock(clock),
    .resetn(resetn),
    .full_reset(full_reset),
    .req(req),
    .route(route6),
    .rdata(rdata6)
  );

  // Samples wait here until a frame starts; a frame takes one pair
  tsr_fifo #(
    .WIDTH(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(sample_valid),
    .in_data(sample_data),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_raw),
    .out_ready(frame_start)
  );

  assign fifo_data = fifo_raw;

  // Edge detection of the sampled serial clocks
  assign rise = bclk && !st.bclk_q;
  assign fall = !bclk && st.bclk_q;
  // Frame begins when frame clock is first seen high on a rising edge
  assign frame_start = rise && fsync && !st.fsync_q;

  // Position inside the frame of the bit about to be sent
  assign cur_slot = st.cnt[TSR_CNT_W-1:TSR_SLOT_LOG2];
  assign cur_bit = st.cnt[TSR_SLOT_LOG2-1:0];
  assign hit5 = st.active && (cur_slot == route5.slot_select);
  assign hit6 = st.active && (cur_slot == route6.slot_select);

  // MSB first; slot bits past the sample width send zero
  always_comb begin
    bit5 = 1'b0;
    bit6 = 1'b0;
    if (cur_bit <= TSR_LAST_SAMPLE_BIT) begin
      bit5 = st.cur.ch5[TSR_LAST_SAMPLE_BIT - cur_bit];
      bit6 = st.cur.ch6[TSR_LAST_SAMPLE_BIT - cur_bit];
    end
  end

  // Frame sequencing, output driver and register read path
  always_comb begin
    next_st = st;
    next_st.bclk_q = bclk;
    next_st.rvalid = 1'b0;
    if (rise) begin
      next_st.fsync_q = fsync;
    end
    if (frame_start) begin
      next_st.active = 1'b1;
      next_st.cnt = '0;
      // An empty FIFO sends silence rather than stale samples
      next_st.cur = fifo_valid ? fifo_data : '0;
    end
    if (fall) begin
      // Channel 5 wins when both channels claim the same slot
      if (hit5 && route5.output_drive) begin
        next_st.oe = 1'b1;
        next_st.sdata = bit5;
      end else if (hit6 && route6.output_drive) begin
        next_st.oe = 1'b1;
        next_st.sdata = bit6;
      end else begin
        // Undriven slot, or drive bit clear: release the line
        next_st.oe = 1'b0;
        next_st.sdata = 1'b0;
      end
      if (st.active) begin
        next_st.cnt = st.cnt + 1'b1;
        // Stop after slot 15; a late frame clock must not wrap to slot 0
        if (st.cnt == TSR_LAST_CNT) begin
          next_st.active = 1'b0;
        end
      end
    end
    if (reg_rd) begin
      next_st.rvalid = 1'b1;
      unique case (reg_addr)
        TSR_ROUTE5_ADDR: next_st.rdata = rdata5;
        TSR_ROUTE6_ADDR: next_st.rdata = rdata6;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sdata_out = st.sdata;
  assign sdata_oe = st.oe;
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;

  // Channel 5 in its slot with drive set is on the line next cycle
  a_ch5_slot_data: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && hit5 && route5.output_drive) |=>
      (sdata_oe && sdata_out == $past(bit5)))
    else $error("channel 5 bit missing from its slot");

  // Drive bit clear floats channel 5's slot unless channel 6 owns it
  a_ch5_float: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && hit5 && !route5.output_drive &&
     !(hit6 && route6.output_drive)) |=> !sdata_oe)
    else $error("channel 5 slot driven with drive bit clear");

  // Channel 6 alone in its slot with drive set is on the line
  a_ch6_slot_data: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && hit6 && !hit5 && route6.output_drive) |=>
      (sdata_oe && sdata_out == $past(bit6)))
    else $error("channel 6 bit missing from its slot");

  // Channel 6 takes a shared slot when channel 5 is released there
  a_ch6_shared: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && hit6 && hit5 && !route5.output_drive &&
     route6.output_drive) |=> (sdata_oe && sdata_out == $past(bit6)))
    else $error("channel 6 missing from a shared slot");

  // Drive bit clear floats channel 6's slot unless channel 5 owns it
  a_ch6_float: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && hit6 && !route6.output_drive &&
     !(hit5 && route5.output_drive)) |=> !sdata_oe)
    else $error("channel 6 slot driven with drive bit clear");

  // Reserved bits of a routing read are zero
  a_rsvd_zero: assert property (
    @(posedge clock) disable iff (!resetn)
    (reg_rd && (reg_addr == TSR_ROUTE5_ADDR ||
     reg_addr == TSR_ROUTE6_ADDR)) |=>
      (reg_rvalid && reg_rdata[TSR_RSVD_MSB:TSR_RSVD_LSB] == 3'h0))
    else $error("reserved routing bits read nonzero");

  // Channel 6 read data follows its register one cycle later
  a_read_back: assert property (
    @(posedge clock) disable iff (!resetn)
    (reg_rd && reg_addr == TSR_ROUTE6_ADDR) |=>
      (reg_rdata == {$past(route6.slot_select), 3'h0,
                     $past(route6.output_drive)}))
    else $error("channel 6 register read mismatch");

  // Channel 5 read returns its live fields
  a_read_ch5: assert property (
    @(posedge clock) disable iff (!resetn)
    (reg_rd && reg_addr == TSR_ROUTE5_ADDR) |=>
      (reg_rvalid && reg_rdata == {$past(route5.slot_select), 3'h0,
                                   $past(route5.output_drive)}))
    else $error("channel 5 register read mismatch");

  // Full reset puts channel 5 back in its default slot, driven
  a_ch5_defaults: assert property (
    @(posedge clock) disable iff (!resetn)
    full_reset |=>
      (route5.slot_select == TSR_ROUTE5_RESET[TSR_SLOT_MSB:TSR_SLOT_LSB] &&
       route5.output_drive == TSR_ROUTE5_RESET[TSR_DRIVE_BIT]))
    else $error("channel 5 routing not restored by full reset");

  // Full reset puts channel 6 back in its default slot, driven
  a_ch6_defaults: assert property (
    @(posedge clock) disable iff (!resetn)
    full_reset |=>
      (route6.slot_select == TSR_ROUTE6_RESET[TSR_SLOT_MSB:TSR_SLOT_LSB] &&
       route6.output_drive == TSR_ROUTE6_RESET[TSR_DRIVE_BIT]))
    else $error("channel 6 routing not restored by full reset");

  // A slot no channel drives leaves the line released
  a_idle_slot: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && !(hit5 && route5.output_drive) &&
     !(hit6 && route6.output_drive)) |=> !sdata_oe)
    else $error("line driven in an unowned slot");

  // Outside a frame the line is released and low
  a_no_frame_float: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && !st.active) |=> (!sdata_oe && !sdata_out))
    else $error("line driven outside a frame");

  // Channel 5 slot bits past the sample width go out as driven zeros
  a_pad_zero: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && hit5 && route5.output_drive &&
     cur_bit > TSR_LAST_SAMPLE_BIT) |=> (sdata_oe && !sdata_out))
    else $error("padding bit of channel 5 slot not zero");

  // Frame start takes the FIFO head and restarts at slot 0
  a_frame_load: assert property (
    @(posedge clock) disable iff (!resetn)
    (frame_start && fifo_valid) |=>
      (st.active && st.cnt == '0 && st.cur == $past(fifo_data)))
    else $error("frame start did not load the head sample");

  // After slot 15 the frame closes, so slot 0 is never sent twice
  a_frame_close: assert property (
    @(posedge clock) disable iff (!resetn)
    (fall && st.active && st.cnt == TSR_LAST_CNT) |=>
      !st.active)
    else $error("frame did not close after the last slot");

  // Every read, and only a read, answers with a one-cycle valid
  a_read_pulse: assert property (
    @(posedge clock) disable iff (!resetn)
    reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after the read strobe");

  // Line level never changes except on a bit clock falling edge
  a_hold_between: assert property (
    @(posedge clock) disable iff (!resetn)
    !fall |=> ($stable(sdata_oe) && $stable(sdata_out)))
    else $error("serial output changed off a falling edge");
endmodule : tsr_slot_router

// >>> tsr_pkg.sv
// Shared constants and types for the TDM slot routing block
package tsr_pkg;
  // Register addresses on the control port
  localparam logic [7:0] TSR_ROUTE5_ADDR = 8'h0e;
  localparam logic [7:0] TSR_ROUTE6_ADDR = 8'h0f;
  // Register reset values
  localparam logic [7:0] TSR_ROUTE5_RESET = 8'h51;
  localparam logic [7:0] TSR_ROUTE6_RESET = 8'h61;
  // Field positions inside a routing register
  localparam int TSR_SLOT_MSB = 7;
  localparam int TSR_SLOT_LSB = 4;
  localparam int TSR_RSVD_MSB = 3;
  localparam int TSR_RSVD_LSB = 1;
  localparam int TSR_DRIVE_BIT = 0;
  localparam logic [2:0] TSR_RSVD_VALUE = 3'h0;
  // Frame geometry
  localparam int TSR_SLOTS = 16;
  localparam int TSR_SLOT_LOG2 = 5;
  localparam int TSR_SLOT_IDX_W = 4;
  localparam int TSR_CNT_W = TSR_SLOT_IDX_W + TSR_SLOT_LOG2;
  localparam int TSR_SAMPLE_W = 24;
  localparam logic [TSR_SLOT_LOG2-1:0] TSR_LAST_SAMPLE_BIT = 5'h17;
  localparam logic [TSR_CNT_W-1:0] TSR_LAST_CNT = 9'h1ff;
  localparam int TSR_FIFO_DEPTH = 16;

  // Decoded view of one routing register
  typedef struct packed {
    logic [TSR_SLOT_IDX_W-1:0] slot_select;
    logic output_drive;
  } tsr_route_s;

  // One frame's worth of samples for the two channels
  typedef struct packed {
    logic [TSR_SAMPLE_W-1:0] ch6;
    logic [TSR_SAMPLE_W-1:0] ch5;
  } tsr_sample_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tsr_reg_req_s;
endpackage : tsr_pkg

// >>> tsr_fifo.sv
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tsr_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic clock,              // System clock
  input wire logic resetn,             // Async reset, active low
  input wire logic in_valid,           // Producer has a word
  input wire logic [WIDTH-1:0] in_data, // Word to store
  output logic in_ready,               // Space available, registered
  output logic out_valid,              // Word available, registered
  output logic [WIDTH-1:0] out_data,   // Head word
  input wire logic out_ready           // Consumer takes the head
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] count;
    logic not_full;
    logic not_empty;
  } tsr_fifo_state_s;

  tsr_fifo_state_s st;
  tsr_fifo_state_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid && st.not_full;
  assign pop = out_ready && st.not_empty;
  assign in_ready = st.not_full;
  assign out_valid = st.not_empty;
  assign out_data = mem[st.rp];

  // Pointer and occupancy update; flags kept as flops
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = (st.wp == LAST_PTR) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == LAST_PTR) ? '0 : st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    next_st.not_full = (next_st.count != FULL_COUNT);
    next_st.not_empty = (next_st.count != '0);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '{wp: '0, rp: '0, count: '0, not_full: 1'b1, not_empty: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[st.wp] <= in_data;
    end
  end
endmodule : tsr_fifo

// >>> tsr_route_reg.sv
// One channel's slot routing and drive register
`timescale 1ns/1ps
module tsr_route_reg
  import tsr_pkg::*;
#(
  parameter logic [7:0] ADDR = TSR_ROUTE5_ADDR,
  parameter logic [7:0] RESET_VALUE = TSR_ROUTE5_RESET
) (
  input wire logic clock,         // System clock
  input wire logic resetn,        // Async reset, active low
  input wire logic full_reset,    // Restore reset value, one-cycle pulse
  input tsr_reg_req_s req,        // Register port request
  output tsr_route_s route,       // Decoded fields, registered
  output logic [7:0] rdata        // Read view of this register
);
  tsr_route_s st;
  tsr_route_s next_st;
  tsr_route_s reset_st;

  assign reset_st.slot_select = RESET_VALUE[TSR_SLOT_MSB:TSR_SLOT_LSB];
  assign reset_st.output_drive = RESET_VALUE[TSR_DRIVE_BIT];
  assign route = st;
  // Reserved bits always read as zero
  assign rdata = {st.slot_select, TSR_RSVD_VALUE, st.output_drive};

  // Write of slot and drive fields; reserved bits dropped
  always_comb begin
    next_st = st;
    if (full_reset) begin
      next_st = reset_st;
    end else if (req.wr && req.addr == ADDR) begin
      next_st.slot_select = req.wdata[TSR_SLOT_MSB:TSR_SLOT_LSB];
      next_st.output_drive = req.wdata[TSR_DRIVE_BIT];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '{slot_select: RESET_VALUE[TSR_SLOT_MSB:TSR_SLOT_LSB],
              output_drive: RESET_VALUE[TSR_DRIVE_BIT]};
    end else begin
      st <= next_st;
    end
  end

  // A write lands in both fields on the next cycle
  a_write_lands: assert property (
    @(posedge clock) disable iff (!resetn)
    (req.wr && req.addr == ADDR && !full_reset) |=>
      (st.slot_select == $past(req.wdata[TSR_SLOT_MSB:TSR_SLOT_LSB]) &&
       st.output_drive == $past(req.wdata[TSR_DRIVE_BIT])))
    else $error("routing register write did not land");
endmodule : tsr_route_reg

// >>> tsr_tdm_host.sv
// Far-end TDM receiver model: makes bit and frame clocks, captures slots
`timescale 1ns/1ps
module tsr_tdm_host (
  input wire logic clock,        // System clock
  output logic bclk,             // Bit clock to the device
  output logic fsync,            // Frame clock to the device
  input wire logic sdata_out,    // Serial data level
  input wire logic sdata_oe,     // Serial data driven
  output logic [31:0] cap_data [16], // Captured slot words
  output logic [5:0] cap_oe [16]     // Driven bit count per slot
);
  // Clocks stand still low between frames
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
  end

  // One bit period, two system clocks high then two low
  task automatic bit_period(input logic fs);
    bclk = 1'b1;
    fsync = fs;
    repeat (2) @(negedge clock);
    bclk = 1'b0;
    repeat (2) @(negedge clock);
  endtask : bit_period

  // Preamble rise with frame clock low, so the next rise starts a frame
  task automatic run_frame();
    for (int j = 0; j < 16; j++) begin
      cap_data[j] = 32'h0;
      cap_oe[j] = 6'h00;
    end
    @(negedge clock);
    bit_period(1'b0);
    for (int n = 0; n < 512; n++) begin
      bit_period(n == 0);
      // Sampled just before the next rise, as a receiver would
      cap_data[n/32] = {cap_data[n/32][30:0], sdata_out};
      cap_oe[n/32] = cap_oe[n/32] + {5'h00, sdata_oe};
    end
  endtask : run_frame
endmodule : tsr_tdm_host

// >>> tsr_tb.sv
// Self-checking bench for the two-channel TDM slot router
`timescale 1ns/1ps
module testbench
  import tsr_pkg::*;
;
  localparam int DEPTH = 4; // Short FIFO keeps fill and drain quick
  logic clock, resetn, reg_wr, reg_rd, full_reset, sample_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r5, r6;
  logic reg_rvalid, sample_ready, bclk, fsync, sdata_out, sdata_oe;
  logic [31:0] cd [16];
  logic [5:0] co [16];
  logic [31:0] seed;
  logic [47:0] q[$];
  tsr_sample_s sample_data;
  int err_count, total_checks, i, k;

  tsr_slot_router #(.FIFO_DEPTH(DEPTH)) tsr_slot_router_inst (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .full_reset(full_reset), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready),
    .bclk(bclk), .fsync(fsync), .sdata_out(sdata_out),
    .sdata_oe(sdata_oe));
  tsr_tdm_host tsr_tdm_host_inst (.clock(clock), .bclk(bclk),
    .fsync(fsync), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .cap_data(cd), .cap_oe(co));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_reg(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_slot(input int s, input logic [31:0] ed, gd,
      input logic [5:0] eo, go);
    total_checks++;
    if (gd !== ed || go !== eo) begin
      err_count++;
      $display("ERROR slot %0d expected %h/%0d seen %h/%0d",
        s, ed, eo, gd, go);
    end
  endtask : chk_slot

  // Strobes are raised and dropped on falling edges, one cycle wide
  task automatic reg_write(input logic [7:0] a, d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, e);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    for (int t = 0; t < 4 && reg_rvalid !== 1'b1; t++) @(negedge clock);
    if (reg_rvalid !== 1'b1) begin
      err_count++;
      $display("ERROR reg_rvalid expected 1 seen %b", reg_rvalid);
      end_of_test();
    end
    chk_reg("reg_rdata", e, reg_rdata);
  endtask : reg_read

  // Reference slot map; an empty FIFO sends zeros, channel 5 wins ties
  task automatic check_frame();
    logic [47:0] wd;
    logic [31:0] ed;
    logic [5:0] eo;
    wd = (q.size() > 0) ? q.pop_front() : 48'h0;
    for (int s = 0; s < 16; s++) begin
      ed = 32'h0;
      eo = 6'h00;
      if (r5[0] && r5[7:4] == 4'(s)) begin
        ed = {wd[23:0], 8'h00};
        eo = 6'h20;
      end else if (r6[0] && r6[7:4] == 4'(s)) begin
        ed = {wd[47:24], 8'h00};
        eo = 6'h20;
      end
      chk_slot(s, ed, cd[s], eo, co[s]);
    end
  endtask : check_frame

  initial begin
    seed = 32'h984b240f;
    err_count = 0;
    total_checks = 0;
    resetn = 1'b0;
    {reg_wr, reg_rd, full_reset, sample_valid} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sample_data = '0;
    r5 = TSR_ROUTE5_RESET;
    r6 = TSR_ROUTE6_RESET;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    reg_read(TSR_ROUTE5_ADDR, r5);
    reg_read(TSR_ROUTE6_ADDR, r6);
    reg_read(8'h10, 8'h00);
    // Offer words until the FIFO refuses
    for (k = 0; k <= 8; k++) begin
      @(negedge clock);
      if (k == 8 || sample_ready !== 1'b1) break;
      sample_valid = 1'b1;
      sample_data = 48'({rnd(), rnd()});
      q.push_back(sample_data);
    end
    sample_valid = 1'b0;
    chk_reg("accepted words", 8'(DEPTH), 8'(k));
    // Boundary slots, shared slots, then random; last frames drain empty
    for (i = 0; i < 6; i++) begin
      if (i > 0) begin
        r5 = 8'(rnd());
        r6 = 8'(rnd());
        if (i == 1) begin
          r5[7:4] = 4'h0;
          r6[7:4] = 4'hf;
        end
        if (i == 2 || i == 3) r6[7:4] = r5[7:4];
        if (i < 4) r6[0] = 1'b1;
        if (i < 3) r5[0] = 1'b1;
        if (i == 3) r5[0] = 1'b0;
        // Lone released slots: channel 6 floats, then channel 5
        if (i >= 4) r6[7:4] = ~r5[7:4];
        if (i == 4) r6[0] = 1'b0;
        if (i == 5) r5[0] = 1'b0;
        reg_write(TSR_ROUTE5_ADDR, r5);
        reg_write(TSR_ROUTE6_ADDR, r6);
        r5 = r5 & 8'hf1;
        r6 = r6 & 8'hf1;
        reg_read(TSR_ROUTE5_ADDR, r5);
        reg_read(TSR_ROUTE6_ADDR, r6);
      end
      tsr_tdm_host_inst.run_frame();
      check_frame();
    end
    chk_reg("sample_ready", 8'h01, {7'h00, sample_ready});
    // Full reset beats a write in the same cycle
    @(negedge clock);
    full_reset = 1'b1;
    reg_wr = 1'b1;
    reg_addr = TSR_ROUTE5_ADDR;
    reg_wdata = 8'h00;
    @(negedge clock);
    full_reset = 1'b0;
    reg_wr = 1'b0;
    r5 = TSR_ROUTE5_RESET;
    r6 = TSR_ROUTE6_RESET;
    reg_read(TSR_ROUTE5_ADDR, r5);
    reg_read(TSR_ROUTE6_ADDR, r6);
    tsr_tdm_host_inst.run_frame();
    check_frame();
    end_of_test();
  end
endmodule : testbench
